//--- nliu_pkg.sv
// Package for the nibble logic and port I/O instruction unit.
// Assumes a single instruction clock; all users import nliu_pkg::*.
package nliu_pkg;

  // ==========================================================================
  // Widths and counts
  localparam int INSTR_W = 10;
  localparam int NIB_W = 4;
  localparam int REG_CNT = 16;
  localparam int PORT_CNT = 4;
  localparam int TBL_AW = 9;

  // ==========================================================================
  // Opcode helpers: drop the two inserted 3-bit groups of ones
  function automatic logic [9:0] squeeze(input logic [15:0] h);
    return {h[12], h[11:8], h[4], h[3:0]};
  endfunction

  function automatic logic [5:0] major(input logic [15:0] h);
    logic [9:0] w;
    w = squeeze(h);
    return w[9:4];
  endfunction

  // ==========================================================================
  // Major codes (upper six bits of the 10-bit word)
  localparam logic [5:0] MAJ_AND_B0 = major(16'hFBE0);
  localparam logic [5:0] MAJ_AND_B1 = major(16'hFAE0);
  localparam logic [5:0] MAJ_AND_LO = major(16'hFBF0);
  localparam logic [5:0] MAJ_AND_HI = major(16'hFAF0);
  localparam logic [5:0] MAJ_OR_B0 = major(16'hFDE0);
  localparam logic [5:0] MAJ_OR_B1 = major(16'hFCE0);
  localparam logic [5:0] MAJ_OR_LO = major(16'hFDF0);
  localparam logic [5:0] MAJ_OR_HI = major(16'hFCF0);
  localparam logic [5:0] MAJ_XOR_B0 = major(16'hF5E0);
  localparam logic [5:0] MAJ_XOR_B1 = major(16'hF4E0);
  localparam logic [5:0] MAJ_XOR_LO = major(16'hF5F0);
  localparam logic [5:0] MAJ_XOR_HI = major(16'hF4F0);
  localparam logic [5:0] MAJ_IN_LO = major(16'hFFF0);
  localparam logic [5:0] MAJ_IN_HI = major(16'hFEF0);
  localparam logic [5:0] MAJ_OUT_LO = major(16'hE5F0);
  localparam logic [5:0] MAJ_OUT_HI = major(16'hE4F0);
  localparam logic [5:0] MAJ_OUT_PAIR = major(16'hE6F0);

  // Minor codes (low hex digit)
  localparam logic [3:0] MIN_TBL = 4'h0;
  localparam logic [3:0] MIN_IMM = 4'h1;
  localparam logic [3:0] MIN_ACC = 4'h3;
  localparam logic [3:0] MIN_PORT0 = 4'h8;
  localparam logic [3:0] MIN_PORT1 = 4'h9;
  localparam logic [3:0] MIN_PORT3 = 4'hB;
  localparam logic [3:0] MIN_PORT4 = 4'hC;

  // ==========================================================================
  // Reset values; port slot 0..3 holds pairs 0, 1, 3, 4
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic CARRY_RST = 1'b0;
  localparam logic [3:0] REG_RST = 4'h0;
  localparam logic [3:0][7:0] PORT_RST = {8'h26, 8'h00, 8'h0D, 8'hFF};

  // ==========================================================================
  // Types
  typedef enum {
    NLIU_OP_NONE, NLIU_OP_AND, NLIU_OP_OR, NLIU_OP_XOR, NLIU_OP_INC,
    NLIU_OP_ROL, NLIU_OP_ROLZ, NLIU_OP_IN, NLIU_OP_OUT, NLIU_OP_OUT_PAIR
  } nliu_op_t;

  typedef enum {
    NLIU_SRC_NONE, NLIU_SRC_BANK0, NLIU_SRC_BANK1, NLIU_SRC_TBL_LO, NLIU_SRC_TBL_HI,
    NLIU_SRC_IMM, NLIU_SRC_PORT_LO, NLIU_SRC_PORT_HI
  } nliu_src_t;

  typedef struct packed {
    logic valid;
    logic [INSTR_W-1:0] word;
    logic [INSTR_W-1:0] operand;
  } nliu_instr_t;

  typedef struct packed {
    logic valid;
    logic bank;
    logic [3:0] idx;
    logic [NIB_W-1:0] data;
  } nliu_dm_wr_t;

  typedef struct packed {
    nliu_op_t op;
    nliu_src_t src;
    logic [3:0] idx;
    logic [1:0] slot;
  } nliu_dec_t;

endpackage

//--- nliu_decoder.sv
// Combinational decoder for the logic and port I/O instruction group.
// Assumes a 10-bit instruction word; words outside the group decode to none.
`timescale 1ns/10ps
module nliu_decoder
  import nliu_pkg::*;
(
  // Instruction word
  input wire logic [INSTR_W-1:0] word_in,
  // Decoded fields
  output nliu_dec_t dec_out
);

  // ==========================================================================
  // Decode
  // Port pair number check; only pairs 0, 1, 3 and 4 exist
  function automatic logic port_ok(input logic [3:0] m);
    return (m == MIN_PORT0) || (m == MIN_PORT1) || (m == MIN_PORT3) || (m == MIN_PORT4);
  endfunction

  logic [5:0] maj;
  logic [3:0] mnr;
  logic lo_grp;
  logic hi_grp;

  // Group by major code, then refine by the low digit
  always_comb begin
    maj = word_in[9:4];
    mnr = word_in[3:0];
    dec_out.op = NLIU_OP_NONE;
    dec_out.src = NLIU_SRC_NONE;
    dec_out.idx = mnr;
    dec_out.slot = (mnr == MIN_PORT0) ? 2'h0 : (mnr == MIN_PORT1) ? 2'h1 : (mnr == MIN_PORT3) ? 2'h2 : 2'h3;
    lo_grp = (maj == MAJ_AND_LO) || (maj == MAJ_OR_LO) || (maj == MAJ_XOR_LO);
    hi_grp = (maj == MAJ_AND_HI) || (maj == MAJ_OR_HI) || (maj == MAJ_XOR_HI);
    case (maj)
      MAJ_AND_B0, MAJ_AND_B1, MAJ_AND_LO, MAJ_AND_HI: dec_out.op = NLIU_OP_AND;
      MAJ_OR_B0, MAJ_OR_B1, MAJ_OR_LO, MAJ_OR_HI: dec_out.op = NLIU_OP_OR;
      MAJ_XOR_B0, MAJ_XOR_B1, MAJ_XOR_LO, MAJ_XOR_HI: dec_out.op = NLIU_OP_XOR;
      default: dec_out.op = NLIU_OP_NONE;
    endcase
    case (maj)
      MAJ_AND_B0, MAJ_OR_B0, MAJ_XOR_B0: dec_out.src = NLIU_SRC_BANK0;
      MAJ_AND_B1, MAJ_OR_B1, MAJ_XOR_B1: dec_out.src = NLIU_SRC_BANK1;
      default: dec_out.src = NLIU_SRC_NONE;
    endcase
    if (lo_grp || hi_grp) begin
      if (mnr == MIN_TBL) begin
        dec_out.src = hi_grp ? NLIU_SRC_TBL_HI : NLIU_SRC_TBL_LO;
      end else if (mnr == MIN_IMM && lo_grp) begin
        dec_out.src = NLIU_SRC_IMM;
      end else if (port_ok(mnr)) begin
        dec_out.src = hi_grp ? NLIU_SRC_PORT_HI : NLIU_SRC_PORT_LO;
      end else begin
        dec_out.op = NLIU_OP_NONE;
      end
    end
    // Accumulator-only and port transfer forms
    if (mnr == MIN_ACC && maj == MAJ_XOR_HI) begin
      dec_out.op = NLIU_OP_INC;
    end else if (mnr == MIN_ACC && maj == MAJ_OR_HI) begin
      dec_out.op = NLIU_OP_ROL;
    end else if (mnr == MIN_ACC && maj == MAJ_IN_HI) begin
      dec_out.op = NLIU_OP_ROLZ;
    end else if (port_ok(mnr) && (maj == MAJ_IN_LO || maj == MAJ_IN_HI)) begin
      dec_out.op = NLIU_OP_IN;
      dec_out.src = (maj == MAJ_IN_HI) ? NLIU_SRC_PORT_HI : NLIU_SRC_PORT_LO;
    end else if (port_ok(mnr) && (maj == MAJ_OUT_LO || maj == MAJ_OUT_HI)) begin
      dec_out.op = NLIU_OP_OUT;
      dec_out.src = (maj == MAJ_OUT_HI) ? NLIU_SRC_PORT_HI : NLIU_SRC_PORT_LO;
    end else if (port_ok(mnr) && maj == MAJ_OUT_PAIR) begin
      dec_out.op = NLIU_OP_OUT_PAIR;
      dec_out.src = NLIU_SRC_IMM;
    end
  end

endmodule

//--- nliu_alu.sv
// Combinational nibble ALU: logic ops, increment and rotate with carry.
// Assumes the operand is already selected by the caller.
`timescale 1ns/10ps
module nliu_alu
  import nliu_pkg::*;
(
  // Operation and operands
  input nliu_op_t op_in,
  input wire logic [NIB_W-1:0] acc_in,
  input wire logic [NIB_W-1:0] opnd_in,
  // Results
  output logic [NIB_W-1:0] res_out,
  output logic carry_out,
  output logic acc_we_out,
  output logic carry_we_out,
  output logic zero_reset_out
);

  // ==========================================================================
  // Operation
  always_comb begin
    res_out = acc_in;
    carry_out = 1'b0;
    acc_we_out = 1'b1;
    carry_we_out = 1'b1;
    zero_reset_out = 1'b0;
    case (op_in)
      NLIU_OP_AND: begin
        res_out = acc_in & opnd_in;
        carry_out = acc_in[3] & opnd_in[3];
      end
      NLIU_OP_OR: begin
        res_out = acc_in | opnd_in;
        carry_out = 1'b0;
      end
      NLIU_OP_XOR: begin
        res_out = acc_in ^ opnd_in;
        carry_out = acc_in[3] & opnd_in[3];
      end
      NLIU_OP_INC: begin
        res_out = acc_in + 4'h1;
        carry_out = (acc_in == 4'hF);
      end
      NLIU_OP_ROL, NLIU_OP_ROLZ: begin
        res_out = {acc_in[2:0], acc_in[3]};
        carry_out = acc_in[3];
        zero_reset_out = (op_in == NLIU_OP_ROLZ) && (acc_in == 4'h0);
      end
      NLIU_OP_IN: begin
        res_out = opnd_in;
        carry_out = 1'b0;
      end
      default: begin
        acc_we_out = 1'b0;
        carry_we_out = 1'b0;
      end
    endcase
  end

endmodule

//--- nliu_core.sv
// Logic and port I/O instruction unit of a small 4-bit controller core.
// Assumes the fetch stage hands over a whole instruction (both words) per
// cycle and the program memory answers a table address combinationally.
`timescale 1ns/10ps
module nliu_core
  import nliu_pkg::*;
#(
  parameter int WORD_W = 10
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Instruction from fetch
  input nliu_pkg::nliu_instr_t instr_in,
  // Data memory writes from the transfer instructions
  input nliu_pkg::nliu_dm_wr_t dm_wr_in,
  // Table lookup in program memory
  input wire logic rom_page_select_in,
  input wire logic [nliu_pkg::INSTR_W-1:0] program_word_bit_in,
  output logic [nliu_pkg::TBL_AW-1:0] rom_addr_out,
  // Core state
  output logic [nliu_pkg::NIB_W-1:0] acc_out,
  output logic carry_flag_out,
  output logic [nliu_pkg::PORT_CNT-1:0][7:0] port_pair_out,
  // Status
  output logic instr_done_out,
  output logic instr_unknown_out,
  output logic internal_reset_out
);

  // ==========================================================================
  // Elaboration check
  if (WORD_W != INSTR_W) begin : g_bad_width
    $error("nliu_core serves only the 10-bit instruction word");
  end

  // ==========================================================================
  // State
  logic [NIB_W-1:0] acc_ff;
  logic [NIB_W-1:0] nxt_acc;
  logic carry_ff;
  logic nxt_carry;
  logic [NIB_W-1:0] bank0_register_ff [REG_CNT];
  logic [NIB_W-1:0] nxt_bank0_register [REG_CNT];
  logic [NIB_W-1:0] bank1_register_ff [REG_CNT];
  logic [NIB_W-1:0] nxt_bank1_register [REG_CNT];
  logic [PORT_CNT-1:0][7:0] port_pair_ff;
  logic [PORT_CNT-1:0][7:0] nxt_port_pair;
  logic [TBL_AW-1:0] rom_addr_ff;
  logic [TBL_AW-1:0] nxt_rom_addr;
  logic done_ff;
  logic nxt_done;
  logic unknown_ff;
  logic nxt_unknown;
  logic ireset_ff;
  logic nxt_ireset;

  // Decode and operand
  nliu_dec_t dec;
  logic [NIB_W-1:0] opnd;
  logic [NIB_W-1:0] alu_res;
  logic alu_carry;
  logic alu_acc_we;
  logic alu_carry_we;
  logic alu_zero_reset;
  logic [7:0] sel_pair;

  // ==========================================================================
  // Decoder and ALU
  nliu_decoder u_decoder (
    .word_in (instr_in.word),
    .dec_out (dec)
  );

  nliu_alu u_alu (
    .op_in (instr_in.valid ? dec.op : NLIU_OP_NONE),
    .acc_in (acc_ff),
    .opnd_in (opnd),
    .res_out (alu_res),
    .carry_out (alu_carry),
    .acc_we_out (alu_acc_we),
    .carry_we_out (alu_carry_we),
    .zero_reset_out (alu_zero_reset)
  );

  // ==========================================================================
  // Operand select
  // Table nibbles come from bits 7..4 or 3..0 of the addressed word
  always_comb begin
    sel_pair = port_pair_ff[dec.slot];
    case (dec.src)
      NLIU_SRC_BANK0: opnd = bank0_register_ff[dec.idx];
      NLIU_SRC_BANK1: opnd = bank1_register_ff[dec.idx];
      NLIU_SRC_TBL_HI: opnd = program_word_bit_in[7:4];
      NLIU_SRC_TBL_LO: opnd = program_word_bit_in[3:0];
      NLIU_SRC_IMM: opnd = instr_in.operand[3:0];
      NLIU_SRC_PORT_LO: opnd = sel_pair[3:0];
      NLIU_SRC_PORT_HI: opnd = sel_pair[7:4];
      default: opnd = 4'h0;
    endcase
  end

  // ==========================================================================
  // Next state
  // Whole instruction resolves in the cycle it is presented
  always_comb begin
    nxt_acc = acc_ff;
    nxt_carry = carry_ff;
    nxt_bank0_register = bank0_register_ff;
    nxt_bank1_register = bank1_register_ff;
    nxt_port_pair = port_pair_ff;
    nxt_done = instr_in.valid;
    nxt_unknown = instr_in.valid && (dec.op == NLIU_OP_NONE);
    nxt_ireset = 1'b0;
    if (alu_zero_reset) begin
      // Full internal reset wins over every other update this cycle
      nxt_acc = ACC_RST;
      nxt_carry = CARRY_RST;
      nxt_port_pair = PORT_RST;
      nxt_ireset = 1'b1;
      for (int i = 0; i < REG_CNT; i++) begin
        nxt_bank0_register[i] = REG_RST;
        nxt_bank1_register[i] = REG_RST;
      end
    end else begin
      if (alu_acc_we) begin
        nxt_acc = alu_res;
      end
      if (alu_carry_we) begin
        nxt_carry = alu_carry;
      end
      // Port writes: single nibble from the accumulator or a full byte
      if (instr_in.valid && dec.op == NLIU_OP_OUT) begin
        if (dec.src == NLIU_SRC_PORT_HI) begin
          nxt_port_pair[dec.slot][7:4] = acc_ff;
        end else begin
          nxt_port_pair[dec.slot][3:0] = acc_ff;
        end
      end
      if (instr_in.valid && dec.op == NLIU_OP_OUT_PAIR) begin
        nxt_port_pair[dec.slot] = instr_in.operand[7:0];
      end
      // Register writes from the data transfer side of the core
      if (dm_wr_in.valid) begin
        if (dm_wr_in.bank) begin
          nxt_bank1_register[dm_wr_in.idx] = dm_wr_in.data;
        end else begin
          nxt_bank0_register[dm_wr_in.idx] = dm_wr_in.data;
        end
      end
    end
    // Table address follows the index register so the next lookup is ready
    nxt_rom_addr = {rom_page_select_in, nxt_bank1_register[0], nxt_bank0_register[0]};
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      acc_ff <= ACC_RST;
      carry_ff <= CARRY_RST;
      port_pair_ff <= PORT_RST;
      rom_addr_ff <= '0;
      done_ff <= 1'b0;
      unknown_ff <= 1'b0;
      ireset_ff <= 1'b0;
      for (int i = 0; i < REG_CNT; i++) begin
        bank0_register_ff[i] <= REG_RST;
        bank1_register_ff[i] <= REG_RST;
      end
    end else begin
      acc_ff <= nxt_acc;
      carry_ff <= nxt_carry;
      port_pair_ff <= nxt_port_pair;
      rom_addr_ff <= nxt_rom_addr;
      done_ff <= nxt_done;
      unknown_ff <= nxt_unknown;
      ireset_ff <= nxt_ireset;
      bank0_register_ff <= nxt_bank0_register;
      bank1_register_ff <= nxt_bank1_register;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops
  assign rom_addr_out = rom_addr_ff;
  assign acc_out = acc_ff;
  assign carry_flag_out = carry_ff;
  assign port_pair_out = port_pair_ff;
  assign instr_done_out = done_ff;
  assign instr_unknown_out = unknown_ff;
  assign internal_reset_out = ireset_ff;

endmodule

//--- nliu_rom_model.sv
// Program memory model for table lookups of the nibble unit.
// Assumes the unit drives the address; the word follows at once.
`timescale 1ns/10ps
module nliu_rom_model
  import nliu_pkg::*;
(
  // Table address
  input wire logic [nliu_pkg::TBL_AW-1:0] addr_in,
  // Stored word
  output logic [nliu_pkg::INSTR_W-1:0] word_out
);
  // Words held squeezed to 10 bits, pattern tied to the address
  assign word_out = {addr_in[8:7], addr_in[7:0] ^ 8'hA6};
endmodule

//--- nliu_core_sva.sv
// Checker for nliu_core, attached by bind.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module nliu_core_sva
  import nliu_pkg::*;
#(
  parameter int WORD_W = 10
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Instruction
  input nliu_pkg::nliu_instr_t instr_in,
  // Core state and status
  input wire logic [nliu_pkg::NIB_W-1:0] acc_out,
  input wire logic carry_flag_out,
  input wire logic [nliu_pkg::PORT_CNT-1:0][7:0] port_pair_out,
  input wire logic instr_done_out,
  input wire logic instr_unknown_out,
  input wire logic internal_reset_out
);
  import nliu_pkg::*;
  // Squeeze a 16-bit code to the stored word
  function automatic logic [9:0] sq(input logic [15:0] h);
    return {h[12], h[11:8], h[4], h[3:0]};
  endfunction
  logic go;
  logic [9:0] w;
  logic [3:0] a;
  logic [3:0] b;
  logic zr;
  logic cy;
  logic [3:0] rl;
  // Helper terms
  assign go = instr_in.valid;
  assign w = instr_in.word;
  assign a = acc_out;
  assign b = instr_in.operand[3:0];
  assign zr = go && w == sq(16'hFEF3) && a == 4'h0;
  assign cy = a[3] & b[3];
  assign rl = {a[2:0], a[3]};
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ==========================================================================
  // Assertions
  a_done_one_cycle: assert property (go |=> instr_done_out)
    else $error("done missing after instruction");
  a_no_done_idle: assert property (!go |=> !instr_done_out)
    else $error("done without instruction");
  a_unknown_done: assert property (instr_unknown_out |-> instr_done_out)
    else $error("unknown without done");
  a_zero_reset: assert property (zr |=> internal_reset_out && a == 4'h0 && !carry_flag_out
    && port_pair_out == PORT_RST) else $error("zero reset state wrong");
  a_reset_cause: assert property (internal_reset_out |-> $past(zr))
    else $error("reset pulse without cause");
  a_rotate_left: assert property (go && (w == sq(16'hFCF3) || (w == sq(16'hFEF3) && a != 4'h0))
    |=> a == $past(rl) && carry_flag_out == $past(a[3])) else $error("rotate wrong");
  a_inc_wrap: assert property (go && w == sq(16'hF4F3)
    |=> a == $past(a) + 4'h1 && carry_flag_out == ($past(a) == 4'hF)) else $error("increment wrong");
  a_or_imm: assert property (go && w == sq(16'hFDF1) |=> a == ($past(a) | $past(b)) && !carry_flag_out)
    else $error("or immediate wrong");
  a_and_imm: assert property (go && w == sq(16'hFBF1) |=> a == ($past(a) & $past(b))
    && carry_flag_out == $past(cy)) else $error("and immediate wrong");
  a_xor_imm: assert property (go && w == sq(16'hF5F1) |=> a == ($past(a) ^ $past(b))
    && carry_flag_out == $past(cy)) else $error("xor immediate wrong");
  a_pair_write: assert property (go && w == sq(16'hE6F8)
    |=> port_pair_out[0] == 8'($past(instr_in.operand))) else $error("port pair write wrong");
  a_ports_hold: assert property (!go |=> $stable(port_pair_out) && $stable(acc_out))
    else $error("state changed while idle");
  // Main scenarios
  c_zero_reset: cover property (zr);
  c_rotate: cover property (go && w == sq(16'hFCF3));
  c_unknown: cover property (instr_unknown_out);
endmodule

bind nliu_core nliu_core_sva #(.WORD_W(WORD_W)) u_sva (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .instr_in(instr_in), .acc_out(acc_out),
  .carry_flag_out(carry_flag_out), .port_pair_out(port_pair_out), .instr_done_out(instr_done_out),
  .instr_unknown_out(instr_unknown_out), .internal_reset_out(internal_reset_out));

//--- nliu_core_bench.sv
// Self-checking bench for nliu_core with a program memory model.
// Assumes results show one cycle after the instruction edge.
`timescale 1ns/10ps
module nliu_core_bench;
  import nliu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  nliu_instr_t instr = '0;
  nliu_dm_wr_t dmw = '0;
  logic page = 1'b0;
  logic [TBL_AW-1:0] raddr;
  logic [INSTR_W-1:0] rword;
  logic [NIB_W-1:0] acc;
  logic cy;
  logic [PORT_CNT-1:0][7:0] ports;
  logic done;
  logic unk;
  logic zrst;
  int error_cnt = 0;
  int comparisons = 0;
  // ==========================================================================
  // Design, memory model and clock
  nliu_core #(.WORD_W(10)) DUT (.ref_clk_in(clk), .rst_n_in(rst_n), .instr_in(instr), .dm_wr_in(dmw),
    .rom_page_select_in(page), .program_word_bit_in(rword), .rom_addr_out(raddr), .acc_out(acc),
    .carry_flag_out(cy), .port_pair_out(ports), .instr_done_out(done), .instr_unknown_out(unk),
    .internal_reset_out(zrst));
  nliu_rom_model rom (.addr_in(raddr), .word_out(rword));
  initial begin
    forever #2 clk = ~clk;
  end
  // Helpers
  function automatic logic [9:0] sq(input logic [15:0] h);
    return {h[12], h[11:8], h[4], h[3:0]};
  endfunction
  function automatic logic [4:0] alu(input int k, input logic [3:0] a, input logic [3:0] b);
    if (k == 0) return {a[3] & b[3], a & b};
    if (k == 1) return {1'b0, a | b};
    return {a[3] & b[3], a ^ b};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One cycle of stimulus, driven at the falling edge
  task automatic step(input logic iv, input logic [15:0] h, input logic [9:0] opd, input logic dv,
                      input logic bk, input logic [3:0] ix, input logic [3:0] d);
    instr.valid = iv;
    instr.word = sq(h);
    instr.operand = opd;
    dmw.valid = dv;
    dmw.bank = bk;
    dmw.idx = ix;
    dmw.data = d;
    @(negedge clk);
  endtask
  task automatic op(input logic [15:0] h, input logic [9:0] opd);
    step(1'b1, h, opd, 1'b0, 1'b0, 4'h0, 4'h0);
    check("done", 32'(done), 32'h1);
  endtask
  // Leaves acc at v and carry at v bit 3
  task automatic setacc(input logic [3:0] v);
    op(16'hFBF1, 10'h0);
    op(16'hFDF1, 10'(v));
    op(16'hFBF1, 10'hF);
  endtask
  // Reset state
  task automatic t_reset();
    check("acc", 32'({cy, acc}), 32'h0);
    check("ports", ports, 32'h26000DFF);
    check("raddr", 32'(raddr), 32'h0);
    $display("test reset finished");
  endtask
  // Register and immediate operands
  task automatic t_regs();
    logic [15:0] c [9] = '{16'hFBE0, 16'hFAE0, 16'hFBF1, 16'hFDE0, 16'hFCE0, 16'hFDF1,
                            16'hF5E0, 16'hF4E0, 16'hF5F1};
    logic [3:0] b;
    logic [3:0] n;
    logic [4:0] e;
    for (int i = 0; i < 9; i++) begin
      b = 4'(9 + 3 * i);
      n = 4'(15 - 2 * i);
      if (i % 3 < 2) step(1'b0, 16'h0, 10'h0, 1'b1, 1'(i % 3), n, b);
      setacc(4'hC);
      e = alu(i / 3, 4'hC, b);
      op(c[i] | (i % 3 < 2 ? 16'(n) : 16'h0), i % 3 < 2 ? 10'(~b) : 10'(b));
      check("reg op", 32'({cy, acc}), 32'(e));
    end
    $display("test registers finished");
  endtask
  // Table operands
  task automatic t_table();
    logic [15:0] c [6] = '{16'hFAF0, 16'hFBF0, 16'hFCF0, 16'hFDF0, 16'hF4F0, 16'hF5F0};
    logic [8:0] ad;
    logic [9:0] wd;
    ad = 9'h135;
    wd = {ad[8:7], ad[7:0] ^ 8'hA6};
    page = 1'b1;
    step(1'b0, 16'h0, 10'h0, 1'b1, 1'b0, 4'h0, 4'h5);
    step(1'b0, 16'h0, 10'h0, 1'b1, 1'b1, 4'h0, 4'h3);
    step(1'b0, 16'h0, 10'h0, 1'b0, 1'b0, 4'h0, 4'h0);
    check("raddr", 32'(raddr), 32'(ad));
    for (int i = 0; i < 6; i++) begin
      setacc(4'hB);
      op(c[i], 10'h0);
      check("tbl op", 32'({cy, acc}), 32'(alu(i / 2, 4'hB, i % 2 ? wd[3:0] : wd[7:4])));
    end
    $display("test table finished");
  endtask
  // Port pairs: write, read, output and logic
  task automatic t_ports();
    logic [3:0] mn [4] = '{4'h8, 4'h9, 4'hB, 4'hC};
    logic [15:0] lg [6] = '{16'hFBF8, 16'hFAF8, 16'hFDF8, 16'hFCF8, 16'hF5F8, 16'hF4F8};
    logic [31:0] ep;
    logic [7:0] d;
    ep = 32'h26000DFF;
    for (int s = 0; s < 4; s++) begin
      d = 8'(8'h3C + 8'h51 * s);
      op(16'hE6F0 | 16'(mn[s]), 10'(d));
      ep[8*s +: 8] = d;
      check("pair", ports, ep);
      setacc(4'h8);
      op(16'hFFF0 | 16'(mn[s]), 10'h0);
      check("in lo", 32'({cy, acc}), 32'(d[3:0]));
      op(16'hFEF0 | 16'(mn[s]), 10'h0);
      check("in hi", 32'({cy, acc}), 32'(d[7:4]));
      op(16'hE5F0 | 16'(mn[s]), 10'h0);
      op(16'hFDF1, 10'hF);
      op(16'hE4F0 | 16'(mn[s]), 10'h0);
      ep[8*s +: 8] = {4'hF, d[7:4]};
      check("out", ports, ep);
    end
    for (int i = 0; i < 6; i++) begin
      setacc(4'hD);
      op(lg[i] | 16'h3, 10'h0);
      check("port op", 32'({cy, acc}), 32'(alu(i / 2, 4'hD, i % 2 ? ep[23:20] : ep[19:16])));
    end
    $display("test ports finished");
  endtask
  // Rotate, increment and zero reset
  task automatic t_rot();
    setacc(4'h9);
    op(16'hFCF3, 10'h0);
    check("rotate", 32'({cy, acc}), 32'h13);
    op(16'hFEF3, 10'h0);
    check("rot nz", 32'({cy, acc, zrst}), 32'h0C);
    setacc(4'hF);
    op(16'hF4F3, 10'h0);
    check("inc wrap", 32'({cy, acc}), 32'h10);
    op(16'hF4F3, 10'h0);
    check("inc", 32'({cy, acc}), 32'h01);
    step(1'b0, 16'h0, 10'h0, 1'b1, 1'b0, 4'h7, 4'h6);
    op(16'hE6F8, 10'h11);
    setacc(4'h0);
    step(1'b1, 16'hFEF3, 10'h0, 1'b1, 1'b0, 4'h7, 4'h9);
    check("zero reset", 32'({cy, acc, zrst}), 32'h01);
    check("ports", ports, 32'h26000DFF);
    op(16'hFDE7, 10'h0);
    check("reg cleared", 32'({cy, acc, zrst}), 32'h0);
    $display("test rotate finished");
  endtask
  // Words outside the group
  task automatic t_unk();
    setacc(4'h5);
    op(16'hE6FA, 10'h0FF);
    check("unknown", 32'({unk, acc}), 32'h15);
    check("ports", ports, 32'h26000DFF);
    op(16'hFFE0, 10'h0);
    check("unknown", 32'(unk), 32'h1);
    $display("test unknown finished");
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_regs();
    t_table();
    t_ports();
    t_rot();
    t_unk();
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
